// ### hw/eec_pkg.sv
/*
  Shared constants and types of the serial EEPROM controller.
  Assumes a 100 MHz system clock and a 128 x 8 three-wire EEPROM.
*/
`default_nettype none
package eec_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_US = 30000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [2:0] SIG_LOCATION = 3'h0;
  localparam logic [2:0] LAST_ADDR_LOCATION = 3'h6;
  localparam logic [4:0] SHORT_CLOCKS = 5'h0A;
  localparam logic [4:0] LONG_CLOCKS = 5'h12;
  localparam logic [4:0] FIRST_DATA_CLOCK = 5'h0B;
  localparam logic [4:0] DATA_PHASE_CLOCK = 5'h0A;
  localparam logic [47:0] STATION_RESET = 48'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [4:0] LINK_RESET_CYCLES = 5'h10;
  // Opcodes and extended-command address prefixes on the wire
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [6:0] EXT_LOCK = 7'h00;
  localparam logic [6:0] EXT_FILL = 7'h20;
  localparam logic [6:0] EXT_ERASE = 7'h40;
  localparam logic [6:0] EXT_UNLOCK = 7'h60;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_MODIFY_LOCK = 3'h1,
    CMD_MODIFY_UNLOCK = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_FILL_EVERYTHING = 3'h4,
    CMD_ERASE = 3'h5,
    CMD_ERASE_EVERYTHING = 3'h6,
    CMD_RELOAD = 3'h7
  } eec_cmd_type;

  typedef struct packed {
    eec_cmd_type command_code_field;
    logic [6:0] target_location_field;
  } eec_host_cmd_type;

  typedef struct packed {
    logic [1:0] op;
    logic [6:0] addr;
    logic [7:0] data;
    logic [4:0] nclk;
    logic poll;
  } eec_frame_type;

  typedef struct packed {
    logic eeprom_shift_clock;
    logic cs;
    logic dout;
    logic doe;
  } eec_pins_type;
endpackage
`default_nettype wire

// ### hw/eec_link.sv
/*
  Serial engine of the EEPROM controller, on the link clock.
  Assumes requests arrive by toggle with the frame held stable until ack.
*/
`timescale 1ns/1ns
`default_nettype none
module eec_link (
  input wire logic link_clk, // Link clock
  input wire logic resetn, // System reset, synchronised here
  input wire logic req_toggle, // New frame request
  input wire eec_pkg::eec_frame_type frame, // Frame, stable at toggle
  input wire logic abort, // Give up polling
  input wire logic din, // Data pin from EEPROM
  output logic ack_toggle, // Frame finished
  output logic [7:0] rdata, // Bits read, held until next frame
  output eec_pkg::eec_pins_type pins // Serial pins
);
  import eec_pkg::*;
  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_GAP, L_POLL} eec_lstate_type;
  eec_lstate_type state;
  logic rst_meta, rst_sync, req_meta, req_sync, req_seen;
  logic abort_meta, abort_sync, din_meta, din_sync;
  logic [1:0] ph;
  logic [4:0] cnt;
  logic [17:0] sh;
  logic cs;
  eec_frame_type cur;

  always_ff @(posedge link_clk) begin
    rst_meta <= resetn;
    rst_sync <= rst_meta;
    req_meta <= req_toggle;
    req_sync <= req_meta;
    abort_meta <= abort;
    abort_sync <= abort_meta;
    din_meta <= din;
    din_sync <= din_meta;
  end

  always_ff @(posedge link_clk) begin
    if (!rst_sync) begin
      state <= L_IDLE;
      ph <= 2'h0;
      cnt <= 5'h00;
      sh <= 18'h0;
      cs <= 1'b0;
      cur <= '0;
      req_seen <= 1'b0;
      ack_toggle <= 1'b0;
      rdata <= DATA_RESET;
    end else begin
      unique case (state)
        L_IDLE: begin
          if (req_sync != req_seen) begin
            req_seen <= req_sync;
            cur <= frame;
            sh <= {1'b1, frame.op, frame.addr, frame.data};
            cs <= 1'b1;
            ph <= 2'h0;
            cnt <= 5'h00;
            state <= L_SHIFT;
          end
        end
        L_SHIFT: begin
          ph <= ph + 2'h1;
          if (ph == 2'h1 && cnt >= FIRST_DATA_CLOCK) begin
            rdata <= {rdata[6:0], din_sync};
          end
          if (ph == 2'h3) begin
            cnt <= cnt + 5'h01;
            sh <= {sh[16:0], 1'b0};
          end
          if (ph == 2'h1 && cnt == cur.nclk) begin
            cs <= 1'b0;
            ph <= 2'h0;
            if (cur.poll) begin
              state <= L_GAP;
            end else begin
              state <= L_IDLE;
              ack_toggle <= ~ack_toggle;
            end
          end
        end
        L_GAP: begin
          ph <= ph + 2'h1;
          if (ph == 2'h3) begin
            cs <= 1'b1;
            state <= L_POLL;
          end
        end
        L_POLL: begin
          if (ph != 2'h3) begin
            ph <= ph + 2'h1;
          end
          // Synchroniser still shows the gap level for a few cycles
          if (abort_sync || (ph == 2'h3 && din_sync)) begin
            cs <= 1'b0;
            ph <= 2'h0;
            state <= L_IDLE;
            ack_toggle <= ~ack_toggle;
          end
        end
      endcase
    end
  end

  assign pins.eeprom_shift_clock = (state == L_SHIFT) && ph[1];
  assign pins.cs = cs;
  assign pins.dout = sh[17];
  assign pins.doe = (state == L_SHIFT) &&
                    (cur.op != OP_READ || cnt < DATA_PHASE_CLOCK);

  // Rising edges seen in the current frame
  logic sck_q;
  logic [4:0] rises;
  always_ff @(posedge link_clk) begin
    if (!rst_sync) begin
      sck_q <= 1'b0;
      rises <= 5'h00;
    end else begin
      sck_q <= pins.eeprom_shift_clock;
      if (state == L_IDLE) begin
        rises <= 5'h00;
      end else if (pins.eeprom_shift_clock && !sck_q) begin
        rises <= rises + 5'h01;
      end
    end
  end

  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_sync);

  a_clock_count: assert property (
    $fell(cs) && $past(state) == L_SHIFT |-> rises == cur.nclk)
    else $error("wrong number of serial clocks in frame");
  a_gap_select: assert property (
    state == L_SHIFT ##1 state == L_GAP |-> !cs [*4] ##1 cs)
    else $error("chip select not dropped for four cycles before poll");
  c_poll_done: cover property (state == L_POLL ##1 state == L_IDLE);
endmodule
`default_nettype wire

// ### hw/eec_ctrl.sv
/*
  Serial EEPROM controller: station address auto-load and host commands.
  Assumes host ports on clk, a free-running link clock, 128 x 8 EEPROM.
*/
// Functional notes
// - After any reset, read location zero; memory present only if signature.
// - On signature, read next six bytes into station address, byte 0 lowest.
// - Set address-loaded flag only after all six bytes are written.
// - Without signature, stop and leave station address untouched.
// - Reload command repeats signature check and load; fails on mismatch.
// - Address-loaded flag set on each successful reload.
// - EEPROM has 128 locations of eight bits.
// - Writing busy starts the command; controller clears busy when done.
// - Read places fetched byte in data register before busy clears.
// - No EEPROM response within timeout: abandon and set timeout flag.
// - Interface disabled: pins act as outputs or observe MII signals.
// - Erase sends single-location erase for target location.
// - Erase-everything sends bulk erase, with timeout reporting.
// - Write sends data register to target location.
// - Fill-everything sends data register to every location.
// - Ten serial clocks for short commands, eighteen for data commands.
`timescale 1ns/1ns
`default_nettype none
module eec_ctrl #(
  parameter int TIMEOUT_CYCLES = eec_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic link_clk, // Serial engine clock
  input wire logic soft_reset, // Pulse: restart address load
  input wire logic cmd_go, // Pulse: write busy bit to one
  input wire eec_pkg::eec_host_cmd_type eeprom_command_reg, // Code, location
  input wire logic data_wr, // Pulse: write data register
  input wire logic [7:0] data_wr_val, // Value for data register
  input wire logic addr_wr, // Pulse: software writes station address
  input wire logic [47:0] addr_wr_val, // Software station address
  input wire logic eeprom_enable, // Interface enabled
  input wire logic pin_mux_sel, // Disabled: 1 MII monitor, 0 outputs
  input wire logic [1:0] gpo_value, // Disabled: clock, data pin values
  input wire logic [1:0] mii_monitor, // Disabled: MII signals to observe
  output logic op_in_progress_flag, // Busy bit
  output logic response_timeout_flag, // Timeout bit
  output logic address_loaded_flag, // Address-loaded bit
  output logic init_done, // Reset-time load attempt finished
  output logic [7:0] eeprom_data_reg, // Data register
  output logic [31:0] station_addr_lower, // Station address bytes 0-3
  output logic [15:0] station_addr_upper, // Station address bytes 4-5
  output logic serial_clock_pin, // Serial clock pin
  output logic chip_select_pin, // EEPROM select
  output logic serial_data_io_out, // Data pin output
  output logic serial_data_io_oe, // Data pin enable
  input wire logic serial_data_io_in // Data pin input
);
  import eec_pkg::*;
  localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYCLES - 1);

  if (TIMEOUT_CYCLES < 2) begin : g_tmo_check
    $error("TIMEOUT_CYCLES must be at least 2");
  end

  typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT, M_ABORT} eec_mstate_type;

  function automatic eec_frame_type make_frame(eec_cmd_type c,
                                               logic [6:0] a,
                                               logic [7:0] d);
    eec_frame_type f;
    f = '{op: OP_EXT, addr: a, data: d, nclk: SHORT_CLOCKS, poll: 1'b1};
    unique case (c)
      CMD_READ, CMD_RELOAD: begin
        f.op = OP_READ;
        f.nclk = LONG_CLOCKS;
        f.poll = 1'b0;
      end
      CMD_WRITE: begin
        f.op = OP_WRITE;
        f.nclk = LONG_CLOCKS;
      end
      CMD_FILL_EVERYTHING: begin
        f.addr = EXT_FILL;
        f.nclk = LONG_CLOCKS;
      end
      CMD_ERASE: f.op = OP_ERASE;
      CMD_ERASE_EVERYTHING: f.addr = EXT_ERASE;
      CMD_MODIFY_UNLOCK: begin
        f.addr = EXT_UNLOCK;
        f.poll = 1'b0;
      end
      CMD_MODIFY_LOCK: begin
        f.addr = EXT_LOCK;
        f.poll = 1'b0;
      end
    endcase
    return f;
  endfunction

  eec_mstate_type state;
  eec_host_cmd_type cur;
  eec_frame_type frame;
  eec_pins_type pins;
  logic req_toggle, link_ack, ack_meta, ack_sync, ack_seen;
  logic [7:0] link_rdata;
  logic loading, load_pending, abort_req;
  logic [2:0] load_idx;
  logic [TMO_W-1:0] tmo_cnt;
  logic [47:0] station_addr;
  logic ack_edge, done, tmo_hit, accept, start_load, sig_ok;
  logic load_next, op_end, byte_wr;
  logic link_resetn;
  logic [4:0] rst_hold;

  eec_link u_link (
    .link_clk(link_clk),
    .resetn(link_resetn),
    .req_toggle(req_toggle),
    .frame(frame),
    .abort(abort_req),
    .din(serial_data_io_in),
    .ack_toggle(link_ack),
    .rdata(link_rdata),
    .pins(pins)
  );

  // Stretch reset so the slower link domain surely sees it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rst_hold <= LINK_RESET_CYCLES;
      link_resetn <= 1'b0;
    end else begin
      if (rst_hold != 5'h00) begin
        rst_hold <= rst_hold - 5'h01;
      end
      link_resetn <= rst_hold == 5'h00;
    end
  end

  // Ack toggle back into clk
  always_ff @(posedge clk) begin
    if (!resetn || !link_resetn) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_meta <= link_ack;
      ack_sync <= ack_meta;
      ack_seen <= ack_sync;
    end
  end

  assign ack_edge = ack_sync ^ ack_seen;
  assign done = (state == M_WAIT) && ack_edge;
  assign tmo_hit = (state == M_WAIT) && !ack_edge && tmo_cnt == TMO_LAST;
  assign start_load = (state == M_IDLE) && load_pending;
  assign accept = (state == M_IDLE) && !load_pending && init_done &&
                  cmd_go && !op_in_progress_flag;
  assign sig_ok = link_rdata == SIGNATURE;
  assign load_next = done && loading &&
                     ((load_idx == SIG_LOCATION) ? sig_ok
                      : load_idx != LAST_ADDR_LOCATION);
  assign op_end = (done && !load_next) || (state == M_ABORT && ack_edge);
  assign byte_wr = done && loading && load_idx != SIG_LOCATION;

  // Sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= M_IDLE;
      cur <= '{command_code_field: CMD_READ, target_location_field: 7'h00};
      frame <= '0;
      req_toggle <= 1'b0;
      loading <= 1'b0;
      load_pending <= 1'b1;
      load_idx <= SIG_LOCATION;
    end else begin
      if (start_load) begin
        load_pending <= 1'b0;
      end
      if (soft_reset) begin
        load_pending <= 1'b1;
      end
      unique case (state)
        M_IDLE: begin
          if (start_load) begin
            loading <= 1'b1;
            load_idx <= SIG_LOCATION;
            state <= M_ISSUE;
          end else if (accept) begin
            cur <= eeprom_command_reg;
            loading <= eeprom_command_reg.command_code_field == CMD_RELOAD;
            load_idx <= SIG_LOCATION;
            state <= M_ISSUE;
          end
        end
        M_ISSUE: begin
          frame <= loading ?
                   make_frame(CMD_READ, {4'h0, load_idx}, DATA_RESET) :
                   make_frame(cur.command_code_field,
                              cur.target_location_field, eeprom_data_reg);
          req_toggle <= ~req_toggle;
          state <= M_WAIT;
        end
        M_WAIT: begin
          if (load_next) begin
            load_idx <= load_idx + 3'h1;
            state <= M_ISSUE;
          end else if (done) begin
            state <= M_IDLE;
          end else if (tmo_hit) begin
            state <= M_ABORT;
          end
        end
        M_ABORT: begin
          if (ack_edge) begin
            state <= M_IDLE;
          end
        end
      endcase
    end
  end

  // Timeout watch and abandon request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tmo_cnt <= '0;
      abort_req <= 1'b0;
    end else begin
      if (state == M_ISSUE) begin
        tmo_cnt <= '0;
      end else if (state == M_WAIT) begin
        tmo_cnt <= tmo_cnt + 1'b1;
      end
      if (tmo_hit) begin
        abort_req <= 1'b1;
      end else if (state == M_ABORT && ack_edge) begin
        abort_req <= 1'b0;
      end
    end
  end

  // Status flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_in_progress_flag <= 1'b0;
      response_timeout_flag <= 1'b0;
      address_loaded_flag <= 1'b0;
      init_done <= 1'b0;
    end else begin
      if (accept) begin
        op_in_progress_flag <= 1'b1;
      end else if (op_end) begin
        op_in_progress_flag <= 1'b0;
      end
      if (accept) begin
        response_timeout_flag <= 1'b0;
      end
      if (tmo_hit) begin
        response_timeout_flag <= 1'b1;
      end
      if (soft_reset) begin
        init_done <= 1'b0;
      end else if (op_end && loading && !load_pending) begin
        init_done <= 1'b1;
      end
      if (start_load || (accept &&
          eeprom_command_reg.command_code_field == CMD_RELOAD)) begin
        address_loaded_flag <= 1'b0;
      end
      if (done && loading && load_idx == LAST_ADDR_LOCATION) begin
        address_loaded_flag <= 1'b1;
      end
    end
  end

  // Data register; a finished read wins over a host write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      eeprom_data_reg <= DATA_RESET;
    end else if (done && !loading &&
                 cur.command_code_field == CMD_READ) begin
      eeprom_data_reg <= link_rdata;
    end else if (data_wr && !op_in_progress_flag) begin
      eeprom_data_reg <= data_wr_val;
    end
  end

  // Station address, byte 0 in the lowest bits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      station_addr <= STATION_RESET;
    end else if (byte_wr) begin
      for (int i = 0; i < 6; i++) begin
        if (load_idx == 3'(i + 1)) begin
          station_addr[8*i +: 8] <= link_rdata;
        end
      end
    end else if (addr_wr) begin
      station_addr <= addr_wr_val;
    end
  end

  assign station_addr_lower = station_addr[31:0];
  assign station_addr_upper = station_addr[47:32];

  // Pins: engine when enabled, outputs or MII monitor when not
  assign serial_clock_pin = eeprom_enable ? pins.eeprom_shift_clock :
                            (pin_mux_sel ? mii_monitor[1] : gpo_value[1]);
  assign serial_data_io_out = eeprom_enable ? pins.dout :
                              (pin_mux_sel ? mii_monitor[0] : gpo_value[0]);
  assign serial_data_io_oe = eeprom_enable ? pins.doe : 1'b1;
  assign chip_select_pin = eeprom_enable && pins.cs;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_sig_gate: assert property (
    done && loading && load_idx == SIG_LOCATION && !sig_ok && !addr_wr
    |=> $stable(station_addr) && state == M_IDLE && !address_loaded_flag)
    else $error("station address touched after signature mismatch");
  a_loaded_after: assert property (
    $rose(address_loaded_flag) |-> $past(load_idx) == LAST_ADDR_LOCATION &&
    $past(byte_wr))
    else $error("address loaded flag set before sixth byte");
  a_byte_order: assert property (
    byte_wr && load_idx == 3'h1 |=> station_addr[7:0] == $past(link_rdata))
    else $error("first address byte not in lowest bits");
  a_busy_start: assert property (
    accept |=> op_in_progress_flag ##1 state == M_WAIT)
    else $error("busy not raised on command start");
  a_read_data: assert property (
    $fell(op_in_progress_flag) && cur.command_code_field == CMD_READ &&
    !response_timeout_flag |-> eeprom_data_reg == $past(link_rdata))
    else $error("read data missing when busy cleared");
  a_timeout_flag: assert property (
    tmo_hit |=> response_timeout_flag && abort_req &&
    op_in_progress_flag == $past(op_in_progress_flag))
    else $error("timeout not flagged");
  a_abort_bound: assert property (
    $rose(abort_req) |-> ##[1:1000] !abort_req && state == M_IDLE)
    else $error("abandoned operation did not end");
  a_reload_fail: assert property (
    accept && eeprom_command_reg.command_code_field == CMD_RELOAD
    |=> loading && !address_loaded_flag)
    else $error("reload did not restart the address load");
  a_pins_disabled: assert property (
    !eeprom_enable |-> !chip_select_pin && serial_data_io_oe)
    else $error("EEPROM selected while interface disabled");
  c_load_ok: cover property ($rose(address_loaded_flag));
  c_timeout: cover property ($rose(response_timeout_flag));
  c_read_done: cover property (
    $fell(op_in_progress_flag) && cur.command_code_field == CMD_READ);
endmodule
`default_nettype wire

// ### tb/eec_eeprom_model.sv
/*
  Behavioural three-wire 128 x 8 EEPROM for the controller bench.
  Assumes the controller shifts on rising serial clock with select high.
*/
`timescale 1ns/1ns
`default_nettype none
module eec_eeprom_model (
  input wire logic sclk, // Serial clock
  input wire logic cs, // Chip select, high active
  input wire logic dout, // Controller data out
  input wire logic doe, // Controller drives data
  input wire logic hang, // Never report ready
  output logic din // Resolved data line
);
  logic [7:0] mem [128];
  logic [17:0] sr;
  logic [7:0] rdv;
  logic unlocked = 1'b0;
  logic pend = 1'b0, exe = 1'b0, rdop = 1'b0;
  logic moe = 1'b0, mval = 1'b0, last = 1'b0;
  int cnt = 0;
  // Released line shows the inverse of the last driven level
  assign din = doe ? dout : (moe ? mval : ~last);
  always @* begin
    if (doe) last = dout;
    else if (moe) last = mval;
  end
  // Busy part holds data low, then raises it when done
  always @(posedge cs) begin
    cnt = 0;
    rdop = 0;
    if (pend) begin
      moe = 1;
      mval = 0;
      #200;
      if (cs && !hang) mval = 1;
    end
  end
  always @(negedge cs) begin
    moe = 0;
    pend = exe;
    exe = 0;
  end
  always @(posedge sclk) if (cs) begin
    cnt++;
    sr = {sr[16:0], dout};
    if (cnt == 10) begin
      rdop = (sr[8:7] == 2'b10);
      rdv = mem[sr[6:0]];
      if (sr[8:7] == 2'b11) begin
        exe = 1;
        if (unlocked) mem[sr[6:0]] = 8'hFF;
      end
      if (sr[8:7] == 2'b00) begin
        case (sr[6:5])
          2'b00: unlocked = 0;
          2'b11: unlocked = 1;
          2'b10: begin
            exe = 1;
            if (unlocked) foreach (mem[i]) mem[i] = 8'hFF;
          end
          default: ;
        endcase
      end
    end
    if (cnt == 18 && !rdop) begin
      exe = 1;
      if (unlocked && sr[16:15] == 2'b01) mem[sr[14:8]] = sr[7:0];
      if (unlocked && sr[16:15] == 2'b00 && sr[14:13] == 2'b01) begin
        foreach (mem[i]) mem[i] = sr[7:0];
      end
    end
  end
  always @(negedge sclk) if (cs && rdop && cnt >= 10 && cnt < 18) begin
    moe = 1;
    mval = rdv[17 - cnt];
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
/*
  Self-checking bench of the EEPROM controller with a shadow memory.
  Assumes the EEPROM model in tb and a shortened response timeout.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import eec_pkg::*;
  logic clk, link_clk, resetn, soft_reset, cmd_go, data_wr, addr_wr;
  logic eeprom_enable, pin_mux_sel, hang;
  logic [1:0] gpo_value, mii_monitor;
  logic [7:0] data_wr_val, dreg, v;
  logic [47:0] addr_wr_val, station;
  eec_host_cmd_type hcmd;
  logic busy, tout, loaded, init_done, sclk, cs, dout, doe, din;
  logic [31:0] lo;
  logic [15:0] hi;
  logic [7:0] exp_mem [128];
  int error_cnt = 0, tests_run = 0, nclk = 0, last_clk = 0, k;
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin link_clk = 0; #3; forever #16 link_clk = ~link_clk; end
  eec_ctrl #(.TIMEOUT_CYCLES(2000)) dut (
    .clk(clk), .resetn(resetn), .link_clk(link_clk),
    .soft_reset(soft_reset), .cmd_go(cmd_go), .eeprom_command_reg(hcmd),
    .data_wr(data_wr), .data_wr_val(data_wr_val), .addr_wr(addr_wr),
    .addr_wr_val(addr_wr_val), .eeprom_enable(eeprom_enable),
    .pin_mux_sel(pin_mux_sel), .gpo_value(gpo_value),
    .mii_monitor(mii_monitor), .op_in_progress_flag(busy),
    .response_timeout_flag(tout), .address_loaded_flag(loaded),
    .init_done(init_done), .eeprom_data_reg(dreg),
    .station_addr_lower(lo), .station_addr_upper(hi),
    .serial_clock_pin(sclk), .chip_select_pin(cs),
    .serial_data_io_out(dout), .serial_data_io_oe(doe),
    .serial_data_io_in(din));
  eec_eeprom_model ee (.sclk(sclk), .cs(cs), .dout(dout), .doe(doe),
    .hang(hang), .din(din));
  // Serial clocks per selected frame
  always @(posedge sclk) if (cs && eeprom_enable) nclk++;
  always @(negedge cs) begin
    if (nclk != 0) last_clk = nclk;
    nclk = 0;
  end
  function automatic logic [47:0] st_exp();
    for (int i = 6; i > 0; i--) st_exp = {st_exp[39:0], exp_mem[i]};
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    int n;
    n = 0;
    while ((init_done !== 1'b1 || busy !== 1'b0) && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check(n < 5000, 1);
  endtask
  task automatic cmd(input eec_cmd_type c, input logic [6:0] loc);
    @(negedge clk);
    cmd_go = 1;
    hcmd = '{c, loc};
    @(negedge clk);
    cmd_go = 0;
    check(busy, 1);
    settle();
  endtask
  task automatic wdata(input logic [7:0] d);
    @(negedge clk);
    data_wr = 1;
    data_wr_val = d;
    @(negedge clk);
    data_wr = 0;
  endtask
  task automatic rd(input int a);
    cmd(CMD_READ, 7'(a));
    check(dreg, exp_mem[a]);
    check(last_clk, 18);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial begin
    {soft_reset, cmd_go, data_wr, addr_wr, hang, pin_mux_sel} = '0;
    {gpo_value, mii_monitor, data_wr_val, addr_wr_val} = '0;
    eeprom_enable = 1;
    resetn = 0;
    hcmd = '0;
    void'($urandom(32'h9E44A2E2));
    for (k = 0; k < 128; k++) begin
      exp_mem[k] = (k == 0) ? SIGNATURE : 8'($urandom);
      ee.mem[k] = exp_mem[k];
    end
    repeat (2) @(negedge clk);
    resetn = 1;
    settle();
    check(loaded, 1);
    check({hi, lo}, st_exp());
    for (k = 0; k < 6; k++) rd($urandom_range(127));
    v = 8'($urandom);
    ee.mem[4] = v;
    exp_mem[4] = v;
    cmd(CMD_RELOAD, 7'h00);
    check(loaded, 1);
    check({hi, lo}, st_exp());
    $display("test load and read done");
    cmd(CMD_MODIFY_UNLOCK, 7'h00);
    check(last_clk, 10);
    k = $urandom_range(127);
    v = 8'($urandom);
    wdata(v);
    cmd(CMD_WRITE, 7'(k));
    exp_mem[k] = v;
    rd(k);
    cmd(CMD_ERASE, 7'(k));
    check(last_clk, 10);
    exp_mem[k] = 8'hFF;
    rd(k);
    v = 8'($urandom);
    wdata(v);
    cmd(CMD_FILL_EVERYTHING, 7'h00);
    foreach (exp_mem[i]) exp_mem[i] = v;
    rd($urandom_range(127));
    cmd(CMD_ERASE_EVERYTHING, 7'h00);
    check(last_clk, 10);
    foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
    rd(k);
    cmd(CMD_MODIFY_LOCK, 7'h00);
    wdata(8'h5A);
    cmd(CMD_WRITE, 7'(k));
    rd(k);
    $display("test modify done");
    cmd(CMD_MODIFY_UNLOCK, 7'h00);
    hang = 1;
    cmd(CMD_ERASE, 7'(k));
    check(tout, 1);
    hang = 0;
    rd(k);
    check(tout, 0);
    station = {hi, lo};
    cmd(CMD_RELOAD, 7'h00);
    check(loaded, 0);
    check({hi, lo}, station);
    @(negedge clk);
    addr_wr = 1;
    addr_wr_val = {16'($urandom), 32'($urandom)};
    @(negedge clk);
    addr_wr = 0;
    @(negedge clk);
    check({hi, lo}, addr_wr_val);
    soft_reset = 1;
    @(negedge clk);
    soft_reset = 0;
    @(negedge clk);
    settle();
    check(loaded, 0);
    check({hi, lo}, addr_wr_val);
    $display("test timeout and reload done");
    eeprom_enable = 0;
    for (k = 0; k < 8; k++) begin
      pin_mux_sel = k[2];
      gpo_value = k[1:0];
      mii_monitor = ~k[1:0];
      repeat (2) @(negedge clk);
      check({sclk, dout, doe}, {k[2] ? ~k[1:0] : k[1:0], 1'b1});
      check(cs, 0);
    end
    $display("test pin reuse done");
    final_report();
  end
endmodule
`default_nettype wire
